// >>> lvt_pkg.sv
package lvt_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FIELD_W = 10;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_LINE_SYNC = 8'h2C;
    localparam logic [ADDR_W-1:0] OFS_LINE_TOTAL = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_ACT_COUNT = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_ACT_START = 8'h38;
    localparam logic [ADDR_W-1:0] OFS_HTOTAL = 8'h60;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h64;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h68;
    localparam logic [FIELD_W-1:0] FIELD_RST = 10'h000;
    localparam logic [FIELD_W-1:0] HTOTAL_RST = 10'h00F;
    localparam logic [FIELD_W-1:0] FIELD_ONE = 10'h001;
    localparam int unsigned HSW_LSB = 16;
    localparam int unsigned HSW_W = 7;
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam int unsigned CTRL_HRTFT_BIT = 1;
    localparam int unsigned STAT_ACTIVE_BIT = 10;
    localparam int unsigned STAT_FRAME_BIT = 11;
    localparam int unsigned MAX_LINES = 1024;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;
endpackage

// >>> lvt_timing.sv
`timescale 1ns/1ps
`default_nettype none
module lvt_timing
    import lvt_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic [lvt_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [lvt_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [lvt_pkg::DATA_W-1:0]     avs_readdata,
    output logic                           avs_waitrequest,
    output logic                           line_sync_pulse,
    output logic                           frame_start,
    output logic                           display_enable,
    output logic [lvt_pkg::FIELD_W-1:0]    line_index
);
    import lvt_pkg::*;

    logic [FIELD_W-1:0] hsync_start_reg;
    logic [HSW_W-1:0]   hsync_width_reg;
    logic [FIELD_W-1:0] frame_line_total_reg;
    logic [FIELD_W-1:0] active_line_count_reg;
    logic [FIELD_W-1:0] active_line_start_reg;
    logic [FIELD_W-1:0] horizontal_total_reg;
    logic               enable_reg;
    logic               high_reflect_panel_reg;
    logic               ack_reg;
    logic [FIELD_W-1:0] pix_reg;
    logic [FIELD_W-1:0] line_reg;
    logic               line_end;
    logic               frame_end;
    logic               in_active;
    logic [FIELD_W:0]   active_end;
    logic [FIELD_W:0]   sync_pos;

    function automatic logic [FIELD_W-1:0] merge10(input logic [FIELD_W-1:0] old,
                                                   input logic [DATA_W-1:0]  wd,
                                                   input logic [3:0]         be);
        logic [FIELD_W-1:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[FIELD_W-1:8] = wd[FIELD_W-1:8];
        end
        return r;
    endfunction

    // one wait cycle per access keeps readdata registered
    assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
    wire wr_go = avs_write && ack_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read || avs_write) && !ack_reg;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hsync_start_reg        <= FIELD_RST;
            hsync_width_reg        <= '0;
            frame_line_total_reg   <= FIELD_RST;
            active_line_count_reg  <= FIELD_RST;
            active_line_start_reg  <= FIELD_RST;
            horizontal_total_reg   <= HTOTAL_RST;
            enable_reg             <= 1'b0;
            high_reflect_panel_reg <= 1'b0;
        end else if (wr_go) begin
            if (avs_address == OFS_LINE_SYNC) begin
                hsync_start_reg <= merge10(hsync_start_reg, avs_writedata, avs_byteenable);
                if (avs_byteenable[2]) begin
                    hsync_width_reg <= avs_writedata[HSW_LSB +: HSW_W];
                end
            end else if (avs_address == OFS_LINE_TOTAL) begin
                frame_line_total_reg <= merge10(frame_line_total_reg, avs_writedata,
                                                avs_byteenable);
            end else if (avs_address == OFS_ACT_COUNT) begin
                active_line_count_reg <= merge10(active_line_count_reg, avs_writedata,
                                                 avs_byteenable);
            end else if (avs_address == OFS_ACT_START) begin
                active_line_start_reg <= merge10(active_line_start_reg, avs_writedata,
                                                 avs_byteenable);
            end else if (avs_address == OFS_HTOTAL) begin
                horizontal_total_reg <= merge10(horizontal_total_reg, avs_writedata,
                                                avs_byteenable);
            end else if (avs_address == OFS_CTRL && avs_byteenable[0]) begin
                enable_reg             <= avs_writedata[CTRL_ENABLE_BIT];
                high_reflect_panel_reg <= avs_writedata[CTRL_HRTFT_BIT];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= DATA_ZERO;
        end else if (avs_read && !ack_reg) begin
            avs_readdata <= DATA_ZERO;
            if (avs_address == OFS_LINE_SYNC) begin
                avs_readdata[FIELD_W-1:0]      <= hsync_start_reg;
                avs_readdata[HSW_LSB +: HSW_W] <= hsync_width_reg;
            end else if (avs_address == OFS_LINE_TOTAL) begin
                avs_readdata[FIELD_W-1:0] <= frame_line_total_reg;
            end else if (avs_address == OFS_ACT_COUNT) begin
                avs_readdata[FIELD_W-1:0] <= active_line_count_reg;
            end else if (avs_address == OFS_ACT_START) begin
                avs_readdata[FIELD_W-1:0] <= active_line_start_reg;
            end else if (avs_address == OFS_HTOTAL) begin
                avs_readdata[FIELD_W-1:0] <= horizontal_total_reg;
            end else if (avs_address == OFS_CTRL) begin
                avs_readdata[CTRL_ENABLE_BIT] <= enable_reg;
                avs_readdata[CTRL_HRTFT_BIT]  <= high_reflect_panel_reg;
            end else if (avs_address == OFS_STATUS) begin
                avs_readdata[FIELD_W-1:0]     <= line_reg;
                avs_readdata[STAT_ACTIVE_BIT] <= in_active;
                avs_readdata[STAT_FRAME_BIT]  <= frame_start;
            end
        end
    end

    // one pixel per clock; the counters idle at zero while disabled
    // a total written below the running count lets it run on to its wrap,
    // so software disables the block before it reprograms the timing
    assign line_end  = (pix_reg == horizontal_total_reg);
    assign frame_end = line_end && (line_reg == frame_line_total_reg);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pix_reg <= FIELD_RST;
        end else if (!enable_reg || line_end) begin
            pix_reg <= FIELD_RST;
        end else begin
            pix_reg <= pix_reg + FIELD_ONE;
        end
    end

    // 10-bit counter reaches line 1023, so 1024 lines fit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_reg <= FIELD_RST;
        end else if (!enable_reg || frame_end) begin
            line_reg <= FIELD_RST;
        end else if (line_end) begin
            line_reg <= line_reg + FIELD_ONE;
        end
    end

    // start used as is, in whole lines, for both TFT kinds
    assign active_end = {1'b0, active_line_start_reg} + {1'b0, active_line_count_reg};
    // lines outside [start, start+count] are the non-display part
    assign in_active = enable_reg && (line_reg >= active_line_start_reg)
                       && ({1'b0, line_reg} <= active_end);
    assign sync_pos = {1'b0, hsync_start_reg} + {{FIELD_W{1'b0}}, 1'b1};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_sync_pulse <= 1'b0;
            frame_start     <= 1'b0;
            display_enable  <= 1'b0;
            line_index      <= FIELD_RST;
        end else begin
            // pulse lasts width+1 pixels from start+1
            line_sync_pulse <= enable_reg && ({1'b0, pix_reg} >= sync_pos)
                               && ({1'b0, pix_reg} <= sync_pos + {4'h0, hsync_width_reg});
            frame_start     <= enable_reg && (line_reg == FIELD_RST) && (pix_reg == FIELD_RST);
            display_enable  <= in_active;
            line_index      <= line_reg;
        end
    end

    a_line_wrap: assert property (@(posedge clk) disable iff (rst)
        frame_end && enable_reg |=> line_reg == FIELD_RST)
        else $error("line counter did not wrap at total");
    a_line_step: assert property (@(posedge clk) disable iff (rst)
        enable_reg && line_end && !frame_end |=> line_reg == $past(line_reg) + FIELD_ONE)
        else $error("line counter did not advance");
    a_active_gate: assert property (@(posedge clk) disable iff (rst)
        enable_reg && line_reg < active_line_start_reg |=> !display_enable)
        else $error("display enabled before start line");
    a_sync_place: assert property (@(posedge clk) disable iff (rst)
        enable_reg && pix_reg == hsync_start_reg |=> !line_sync_pulse)
        else $error("sync began one pixel early");
    a_sync_start: assert property (@(posedge clk) disable iff (rst)
        enable_reg && {1'b0, pix_reg} == sync_pos |=> line_sync_pulse)
        else $error("sync did not begin at start plus one");
    a_active_start: assert property (@(posedge clk) disable iff (rst)
        enable_reg && line_reg == active_line_start_reg |=> display_enable)
        else $error("display not enabled at start line");
    a_active_stop: assert property (@(posedge clk) disable iff (rst)
        enable_reg && {1'b0, line_reg} > active_end |=> !display_enable)
        else $error("display enabled past count plus one lines");
    a_pix_wrap: assert property (@(posedge clk) disable iff (rst)
        enable_reg && line_end |=> pix_reg == FIELD_RST)
        else $error("pixel counter did not wrap at line end");

    c_frame: cover property (@(posedge clk) disable iff (rst) frame_start);
    c_active: cover property (@(posedge clk) disable iff (rst) $rose(display_enable));
    c_sync: cover property (@(posedge clk) disable iff (rst) $rose(line_sync_pulse));
    c_wrap: cover property (@(posedge clk) disable iff (rst) enable_reg && frame_end);
endmodule
`default_nettype wire

// >>> lvt_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module lvt_panel_model (
    input  wire logic       clk,
    input  wire logic       line_sync_pulse,
    input  wire logic       frame_start,
    input  wire logic       display_enable,
    input  wire logic [9:0] line_index,
    output logic [31:0]     frame_len,
    output logic [31:0]     act_len,
    output logic [31:0]     sync_ofs,
    output logic [31:0]     first_line,
    output logic [31:0]     max_line
);
    logic [31:0] cnt, act, mx;
    logic        de_q, sy_q, got;
    // passive panel: it only measures each frame, the first one after enable is junk
    always_ff @(posedge clk) begin
        de_q <= display_enable;
        sy_q <= line_sync_pulse;
        cnt  <= frame_start ? 32'h0 : cnt + 32'h1;
        act  <= (frame_start ? 32'h0 : act) + {31'h0, display_enable};
        mx   <= frame_start ? 32'h0 : ((line_index > mx[9:0]) ? {22'h0, line_index} : mx);
        if (frame_start) begin
            frame_len <= cnt + 32'h1;
            act_len   <= act;
            max_line  <= mx;
            got       <= 1'b0;
        end else if (line_sync_pulse && !sy_q && !got) begin
            sync_ofs <= cnt + 32'h1;
            got      <= 1'b1;
        end
        if (display_enable && !de_q) first_line <= {22'h0, line_index};
    end
endmodule
`default_nettype wire

// >>> lvt_timing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lvt_timing_tb;
    import lvt_pkg::*;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               avs_read = 1'b0;
    logic               avs_write = 1'b0;
    logic [ADDR_W-1:0]  avs_address = 8'h00;
    logic [DATA_W-1:0]  avs_writedata = 32'h0;
    logic [3:0]         avs_byteenable = 4'hF;
    logic [DATA_W-1:0]  avs_readdata, rd;
    logic               avs_waitrequest, line_sync_pulse, frame_start, display_enable;
    logic [FIELD_W-1:0] line_index;
    logic [31:0]        frame_len, act_len, sync_ofs, first_line, max_line;
    int                 bad_count = 0;
    int                 n_tests = 0;
    int                 cycles = 0;
    always #2.5 clk = ~clk;
    lvt_timing dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .line_sync_pulse(line_sync_pulse), .frame_start(frame_start),
        .display_enable(display_enable), .line_index(line_index));
    lvt_panel_model panel (.clk(clk), .line_sync_pulse(line_sync_pulse),
        .frame_start(frame_start), .display_enable(display_enable), .line_index(line_index),
        .frame_len(frame_len), .act_len(act_len), .sync_ofs(sync_ofs),
        .first_line(first_line), .max_line(max_line));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // design flops update after this process wakes, so it sees what the edge samples
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), exp, rd);
    endtask
    task automatic run_cfg(input logic [9:0] ht, vt, cn, st, ss, input logic [6:0] sw,
                           input logic hr);
        logic [31:0] f, a;
        f = ({22'h0, vt} + 32'h1) * ({22'h0, ht} + 32'h1);
        a = ({22'h0, cn} + 32'h1) * ({22'h0, ht} + 32'h1);
        // counters restart cleanly only from a disabled state
        bus(1'b1, OFS_CTRL, 32'h0);
        bus(1'b1, OFS_HTOTAL, {22'h0, ht});
        bus(1'b1, OFS_LINE_SYNC, {9'h0, sw, 6'h0, ss});
        bus(1'b1, OFS_LINE_TOTAL, {22'h0, vt});
        bus(1'b1, OFS_ACT_COUNT, {22'h0, cn});
        bus(1'b1, OFS_ACT_START, {22'h0, st});
        bus(1'b1, OFS_CTRL, {30'h0, hr, 1'b1});
        rchk(OFS_CTRL, {30'h0, hr, 1'b1});
        repeat (3 * f + 20) @(posedge clk);
        check("frame_len", f, frame_len);
        check("max_line", {22'h0, vt}, max_line);
        check("act_len", a, act_len);
        check("first_line", {22'h0, st}, first_line);
        check("sync_ofs", {22'h0, ss} + 32'h1, sync_ofs);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rchk(OFS_LINE_TOTAL, 32'h0);
        rchk(OFS_ACT_COUNT, 32'h0);
        rchk(OFS_ACT_START, 32'h0);
        rchk(OFS_HTOTAL, {22'h0, HTOTAL_RST});
        bus(1'b1, 8'h50, 32'hFFFFFFFF);
        rchk(8'h50, 32'h0);
        $display("test reset_and_map done");
        bus(1'b1, OFS_LINE_TOTAL, 32'hFFFFFFFF);
        rchk(OFS_LINE_TOTAL, 32'h3FF);
        avs_byteenable <= 4'h1;
        bus(1'b1, OFS_LINE_TOTAL, 32'h0);
        avs_byteenable <= 4'hF;
        rchk(OFS_LINE_TOTAL, 32'h300);
        $display("test max_total done");
        run_cfg(10'h007, 10'h009, 10'h003, 10'h002, 10'h001, 7'h02, 1'b1);
        $display("test tft_frame done");
        run_cfg(10'h003, 10'h004, 10'h001, 10'h000, 10'h000, 7'h01, 1'b0);
        $display("test zero_start done");
        bus(1'b1, OFS_CTRL, 32'h0);
        rchk(OFS_STATUS, 32'h0);
        $display("test disable_idle done");
        report_and_stop();
    end
endmodule
`default_nettype wire
